// ---- core/tcu_pkg.sv ----
`default_nettype none
package tcu_pkg;
    // Clock and timer base
    localparam int CLK_FREQ_HZ   = 125_000_000;
    localparam int TICK_FREQ_HZ  = 1_000_000;
    localparam int TICK_CYCLES   = CLK_FREQ_HZ / TICK_FREQ_HZ;
    localparam int TICK_CNT_W    = 7;
    localparam int TIMER_W       = 12;
    localparam int TICK128_US    = 128;
    localparam int TICK1024_US   = 1024;
    localparam int NUM_SRC       = 10;
    localparam int VEC_W         = 4;
    localparam int GPIO_W        = 16;
    localparam int PRESCALE_MAX  = 4;

    // Source indices, lower index wins arbitration
    localparam int SRC_BUS_RESET = 0;
    localparam int SRC_TICK128   = 1;
    localparam int SRC_TICK1024  = 2;
    localparam int SRC_EP0       = 3;
    localparam int SRC_CAP_A     = 6;
    localparam int SRC_CAP_B     = 7;
    localparam int SRC_WAKE      = 8;
    localparam int SRC_GPIO      = 9;

    // Register offsets
    localparam logic [4:0] ADDR_TIMER_LO   = 5'h00;
    localparam logic [4:0] ADDR_TIMER_HI   = 5'h01;
    localparam logic [4:0] ADDR_IRQ_EN_LO  = 5'h02;
    localparam logic [4:0] ADDR_IRQ_EN_HI  = 5'h03;
    localparam logic [4:0] ADDR_GLOBAL_EN  = 5'h04;
    localparam logic [4:0] ADDR_GMASK_P0   = 5'h05;
    localparam logic [4:0] ADDR_GMASK_P1   = 5'h06;
    localparam logic [4:0] ADDR_GPOL_P0    = 5'h07;
    localparam logic [4:0] ADDR_GPOL_P1    = 5'h08;
    localparam logic [4:0] ADDR_CAP_CFG    = 5'h09;
    localparam logic [4:0] ADDR_CAP_A_RISE = 5'h0a;
    localparam logic [4:0] ADDR_CAP_A_FALL = 5'h0b;
    localparam logic [4:0] ADDR_CAP_B_RISE = 5'h0c;
    localparam logic [4:0] ADDR_CAP_B_FALL = 5'h0d;
    localparam logic [4:0] ADDR_CAP_STAT   = 5'h0e;
    localparam logic [4:0] ADDR_PEND_LO    = 5'h0f;
    localparam logic [4:0] ADDR_PEND_HI    = 5'h10;
    localparam logic [4:0] ADDR_PS2_MODE   = 5'h11;

    // Capture config fields
    localparam int CFG_PRE_LSB    = 0;
    localparam int CFG_A_RISE_BIT = 3;
    localparam int CFG_A_FALL_BIT = 4;
    localparam int CFG_B_RISE_BIT = 5;
    localparam int CFG_B_FALL_BIT = 6;

    // Reset values
    localparam logic [7:0]         RST_BYTE    = 8'h00;
    localparam logic [NUM_SRC-1:0] RST_SRC     = 10'h000;
    localparam logic [GPIO_W-1:0]  RST_GPIO    = 16'h0000;
    localparam logic [TIMER_W-1:0] RST_TIMER   = 12'h000;
endpackage : tcu_pkg
`default_nettype wire

// ---- core/tcu_top.sv ----
// Contract
// R1: Ten interrupt sources, each individually maskable, each with its own vector.
// R2: Sources: bus reset, 128us tick, 1.024ms tick, three endpoints, captures, wake, GPIO.
// R3: All enabled GPIO pins share one common GPIO request and vector.
// R4: Enabled timer tick sources request periodically at their tick rate.
// R5: Endpoint request only after a completed transaction on that endpoint.
// R6: Capture requests whenever it latches a value on the selected edge.
// R7: Per-pin GPIO mask; masked pins never cause the GPIO request.
// R8: Per-pin polarity selects rising or falling edge for GPIO interrupt.
// R9: Twelve-bit free-running counter at 1 MHz feeds both tick sources.
// R10: Free-running count readable any time; firmware subtracts two readings.
// R11: Four capture registers latch programmable 8-bit count slice; rise and fall separate.
// R12: Capture pin A feeds capture A, pin B feeds capture B only.
// R13: In PS/2 mode, an interrupt signals start of activity on the lines.
// R14: Acknowledge disables interrupts and pushes state; return op re-enables.
// R15: Pending held until vector taken; fixed priority picks among pending sources. Here a pending-register read also clears the flags.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`default_nettype none
module tcu_top
    import tcu_pkg::*;
#(
    parameter int GPIO_WIDTH = GPIO_W
) (
    // Clock, reset, enable
    input  wire logic                  clock_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  ce_in,
    // Register port
    input  wire logic [4:0]            addr_in,
    input  wire logic [7:0]            wr_data_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic      [7:0]            rd_data_out,
    // Event inputs
    // Port 0 is gpio_in[7:0], port 1 is gpio_in[15:8]
    // Capture pins A and B are gpio_in[0] and gpio_in[1]
    input  wire logic                  bus_reset_in,
    input  wire logic [2:0]            ep_done_in,
    input  wire logic                  wake_in,
    input  wire logic [GPIO_WIDTH-1:0] gpio_in,
    input  wire logic                  ps2_data_line_in,
    // CPU side
    input  wire logic                  irq_ack_in,
    input  wire logic                  return_from_interrupt_op_in,
    output logic                       irq_req_out,
    output logic      [VEC_W-1:0]      vector_out,
    output logic                       stack_push_out
);
    // State
    logic [TICK_CNT_W-1:0] pre_reg, pre_next;
    logic [TIMER_W-1:0]    timer_reg, timer_next;
    // High half frozen by a low-half read so a pair of reads agrees
    logic [3:0]            snap_hi_reg, snap_hi_next;

    // Source enables, pending flags and the CPU's global enable
    logic [NUM_SRC-1:0]    en_reg, en_next;
    logic [NUM_SRC-1:0]    pend_reg, pend_next;
    logic                  gie_reg, gie_next;

    // GPIO mask, edge polarity and last sampled pin levels
    logic [GPIO_WIDTH-1:0] gmask_reg, gmask_next;
    logic [GPIO_WIDTH-1:0] gpol_reg, gpol_next;
    logic [GPIO_WIDTH-1:0] gprev_reg, gprev_next;

    // Capture prescale and edge selects, then the four slices
    logic [7:0]            cfg_reg, cfg_next;
    logic [7:0]            cap_reg [4];
    logic [7:0]            cap_next [4];

    // Capture status, PS/2 mode and last data line level
    logic [3:0]            cstat_reg, cstat_next;
    logic                  ps2_mode_reg, ps2_mode_next;
    logic                  ps2_prev_reg, ps2_prev_next;

    // Next values of the registered outputs
    logic [7:0]            rd_next;
    logic                  irq_next;
    logic [VEC_W-1:0]      vec_next;
    logic                  push_next;

    // Per-pin GPIO edge qualification
    // Pins are synchronous, so one stored sample gives the edge
    // Masked pins drop out before the OR into the shared request
    logic [GPIO_WIDTH-1:0] gpio_hit;
    genvar g;
    generate
        for (g = 0; g < GPIO_WIDTH; g++) begin : g_gpio
            // Polarity 1 picks rising edge, 0 picks falling
            assign gpio_hit[g] = gmask_reg[g] &                                         // R7
                                 (gpol_reg[g] ? (gpio_in[g] & ~gprev_reg[g])
                                              : (~gpio_in[g] & gprev_reg[g]));          // R8
        end
    endgenerate

    // Timer, capture and event logic
    logic                  tick;
    logic [TIMER_W-1:0]    shifted;
    logic [7:0]            slice;
    // Edge terms of the two capture pins, one per selected edge
    logic                  a_rise, a_fall, b_rise, b_fall;
    logic [NUM_SRC-1:0]    events;
    logic [NUM_SRC-1:0]    ready;
    logic                  found;

    always_comb begin
        // Prescaler divides the clock down to the 1 MHz count rate
        tick       = (pre_reg == TICK_CNT_W'(TICK_CYCLES - 1));
        pre_next   = tick ? '0 : pre_reg + 1'b1;
        timer_next = tick ? timer_reg + 1'b1 : timer_reg;                              // R9
        // Count wraps at twelve bits; a firmware difference taken
        // modulo the width still gives the right interval
        // Prescale clamps at the fifth setting
        shifted    = timer_reg >> ((cfg_reg[2:0] > 3'(PRESCALE_MAX)) ? 3'(PRESCALE_MAX)
                                                                      : cfg_reg[2:0]);
        slice      = shifted[7:0];                                                     // R11
        a_rise     = cfg_reg[CFG_A_RISE_BIT] & gpio_in[0] & ~gprev_reg[0];             // R12
        a_fall     = cfg_reg[CFG_A_FALL_BIT] & ~gpio_in[0] & gprev_reg[0];
        b_rise     = cfg_reg[CFG_B_RISE_BIT] & gpio_in[1] & ~gprev_reg[1];
        b_fall     = cfg_reg[CFG_B_FALL_BIT] & ~gpio_in[1] & gprev_reg[1];

        // Samples for the next cycle's edge detectors
        gprev_next    = gpio_in;
        ps2_prev_next = ps2_data_line_in;

        // Captures hold until their selected edge comes
        for (int i = 0; i < 4; i++) begin
            cap_next[i] = cap_reg[i];
        end
        // The slice is the count before this edge's increment
        if (a_rise) cap_next[0] = slice;                                               // R11
        if (a_fall) cap_next[1] = slice;
        if (b_rise) cap_next[2] = slice;
        if (b_fall) cap_next[3] = slice;

        // Event vector; PS/2 start is a falling data line, shared with bus reset
        events = '0;
        events[SRC_BUS_RESET] = bus_reset_in |
                                (ps2_mode_reg & ps2_prev_reg & ~ps2_data_line_in);     // R13
        // Ticks fire as the low count bits wrap, once per period
        events[SRC_TICK128]   = tick & (timer_reg[6:0] == 7'(TICK128_US - 1));         // R4
        events[SRC_TICK1024]  = tick & (timer_reg[9:0] == 10'(TICK1024_US - 1));       // R4
        events[SRC_EP0 +: 3]  = ep_done_in;                                            // R5
        events[SRC_CAP_A]     = a_rise | a_fall;                                       // R6
        events[SRC_CAP_B]     = b_rise | b_fall;                                       // R6
        // Wake and endpoint pulses come from engines outside this block
        events[SRC_WAKE]      = wake_in;                                               // R2
        events[SRC_GPIO]      = |gpio_hit;                                             // R3
    end

    // Register writes, reads, pending flags and dispatch
    always_comb begin
        // Everything holds by default; read data and the push strobe fall back to zero
        en_next       = en_reg;
        gie_next      = gie_reg;
        gmask_next    = gmask_reg;
        gpol_next     = gpol_reg;
        cfg_next      = cfg_reg;
        ps2_mode_next = ps2_mode_reg;
        snap_hi_next  = snap_hi_reg;
        pend_next     = pend_reg;
        cstat_next    = cstat_reg;
        rd_next       = RST_BYTE;
        push_next     = 1'b0;

        if (wr_in) begin
            // Unmapped writes fall through and change nothing
            case (addr_in)
                ADDR_IRQ_EN_LO: en_next[7:0]    = wr_data_in;                          // R1
                ADDR_IRQ_EN_HI: en_next[9:8]    = wr_data_in[1:0];
                ADDR_GLOBAL_EN: gie_next        = wr_data_in[0];
                ADDR_GMASK_P0:  gmask_next[7:0] = wr_data_in;
                ADDR_GMASK_P1:  gmask_next[GPIO_WIDTH-1:8] = wr_data_in[GPIO_WIDTH-9:0];
                ADDR_GPOL_P0:   gpol_next[7:0]  = wr_data_in;
                ADDR_GPOL_P1:   gpol_next[GPIO_WIDTH-1:8] = wr_data_in[GPIO_WIDTH-9:0];
                ADDR_CAP_CFG:   cfg_next        = wr_data_in;
                ADDR_PS2_MODE:  ps2_mode_next   = wr_data_in[0];
                default: ;
            endcase
        end

        // Reads; pending and capture status clear on read
        // Hazard: a high-half read with no low read first is stale
        if (rd_in) begin
            case (addr_in)
                ADDR_TIMER_LO: begin
                    rd_next      = timer_reg[7:0];                                     // R10
                    snap_hi_next = timer_reg[11:8];
                end
                ADDR_TIMER_HI:   rd_next = {4'h0, snap_hi_reg};                        // R10
                ADDR_IRQ_EN_LO:  rd_next = en_reg[7:0];
                ADDR_IRQ_EN_HI:  rd_next = {6'h00, en_reg[9:8]};
                ADDR_GLOBAL_EN:  rd_next = {7'h00, gie_reg};
                ADDR_GMASK_P0:   rd_next = gmask_reg[7:0];
                ADDR_GMASK_P1:   rd_next = gmask_reg[GPIO_WIDTH-1:8];
                ADDR_GPOL_P0:    rd_next = gpol_reg[7:0];
                ADDR_GPOL_P1:    rd_next = gpol_reg[GPIO_WIDTH-1:8];
                ADDR_CAP_CFG:    rd_next = cfg_reg;
                ADDR_CAP_A_RISE: rd_next = cap_reg[0];
                ADDR_CAP_A_FALL: rd_next = cap_reg[1];
                ADDR_CAP_B_RISE: rd_next = cap_reg[2];
                ADDR_CAP_B_FALL: rd_next = cap_reg[3];
                ADDR_CAP_STAT: begin
                    rd_next    = {4'h0, cstat_reg};
                    cstat_next = 4'h0;
                end
                ADDR_PEND_LO: begin
                    rd_next        = pend_reg[7:0];
                    pend_next[7:0] = 8'h00;
                end
                ADDR_PEND_HI: begin
                    rd_next        = {6'h00, pend_reg[9:8]};
                    pend_next[9:8] = 2'b00;
                end
                ADDR_PS2_MODE:   rd_next = {7'h00, ps2_mode_reg};
                default:         rd_next = RST_BYTE;
            endcase
        end

        // Ack and return come after the write, so the CPU side wins
        // Acknowledge takes the presented vector and masks further requests
        if (irq_ack_in && irq_req_out) begin
            pend_next[vector_out] = 1'b0;                                              // R15
            gie_next  = 1'b0;                                                          // R14
            push_next = 1'b1;                                                          // R14
        end
        // Return op re-enables; firmware may also write the enable
        if (return_from_interrupt_op_in) begin
            gie_next = 1'b1;                                                           // R14
        end

        // Set wins over any clear in the same cycle
        pend_next  = pend_next | events;                                               // R15
        // Capture status follows the same set-wins order
        cstat_next = cstat_next | {b_fall, b_rise, a_fall, a_rise};

        // Lowest index wins; disabled sources stay pending but never dispatch
        ready    = pend_reg & en_reg;                                                  // R1
        // Vector holds its last value while nothing is ready
        vec_next = vector_out;
        found    = 1'b0;
        // Scan from the top so the lowest ready index is written last
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (ready[i]) begin
                vec_next = VEC_W'(i);                                                  // R15
                found    = 1'b1;
            end
        end
        // Request drops the cycle after acknowledge since enable clears
        irq_next = found & gie_next & ~(irq_ack_in & irq_req_out);                     // R14
    end

    // Registers; clock enable freezes everything
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // Constants only, so no state feeds the reset path
            pre_reg        <= '0;
            timer_reg      <= RST_TIMER;
            snap_hi_reg    <= 4'h0;
            en_reg         <= RST_SRC;
            pend_reg       <= RST_SRC;
            gie_reg        <= 1'b0;
            gmask_reg      <= RST_GPIO;
            gpol_reg       <= RST_GPIO;
            gprev_reg      <= RST_GPIO;
            cfg_reg        <= RST_BYTE;
            // Capture slices clear together
            for (int i = 0; i < 4; i++) begin
                cap_reg[i] <= RST_BYTE;
            end
            cstat_reg      <= 4'h0;
            ps2_mode_reg   <= 1'b0;
            ps2_prev_reg   <= 1'b1;
            rd_data_out    <= RST_BYTE;
            // A request also needs the global enable set first
            irq_req_out    <= 1'b0;
            vector_out     <= '0;
            stack_push_out <= 1'b0;
        end else if (ce_in) begin
            // Enable low holds state, outputs and the prescaler alike
            pre_reg        <= pre_next;
            timer_reg      <= timer_next;
            snap_hi_reg    <= snap_hi_next;
            en_reg         <= en_next;
            pend_reg       <= pend_next;
            gie_reg        <= gie_next;
            gmask_reg      <= gmask_next;
            gpol_reg       <= gpol_next;
            gprev_reg      <= gprev_next;
            cfg_reg        <= cfg_next;
            for (int i = 0; i < 4; i++) begin
                cap_reg[i] <= cap_next[i];
            end
            cstat_reg      <= cstat_next;
            ps2_mode_reg   <= ps2_mode_next;
            ps2_prev_reg   <= ps2_prev_next;
            // Registered outputs, straight from flops
            rd_data_out    <= rd_next;
            irq_req_out    <= irq_next;
            vector_out     <= vec_next;
            stack_push_out <= push_next;
        end
    end
endmodule : tcu_top
`default_nettype wire

// ---- verif/tcu_cpu_model.sv ----
`default_nettype none
module tcu_cpu_model
    import tcu_pkg::*;
(
    // Clock and reset
    input  wire logic             clock_in,
    input  wire logic             rst_n_in,
    // Controller side
    input  wire logic             irq_req_in,
    input  wire logic [VEC_W-1:0] vector_in,
    output logic                  ack_out,
    output logic                  ret_out,
    // Bench side
    input  wire logic [3:0]       delay_in,
    output logic      [VEC_W-1:0] taken_vec_out,
    output logic      [7:0]       taken_cnt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       busy_reg;
    logic [3:0] wait_reg;
    // Ack once per request, then leave the handler after delay_in cycles
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_out       <= 1'b0;
            ret_out       <= 1'b0;
            busy_reg      <= 1'b0;
            wait_reg      <= 4'h0;
            taken_vec_out <= '0;
            taken_cnt_out <= 8'h00;
        end else begin
            ack_out <= 1'b0;
            ret_out <= 1'b0;
            if (busy_reg) begin
                wait_reg <= wait_reg - 4'h1;
                if (wait_reg == 4'h0) begin
                    ret_out  <= 1'b1;
                    busy_reg <= 1'b0;
                end
            end else if (irq_req_in && !ack_out && !ret_out) begin
                // Guard on ret_out: the request needs a cycle to come back
                ack_out       <= 1'b1;
                busy_reg      <= 1'b1;
                wait_reg      <= delay_in;
                taken_vec_out <= vector_in;
                taken_cnt_out <= taken_cnt_out + 8'h01;
            end
        end
    end
endmodule : tcu_cpu_model
`default_nettype wire

// ---- verif/tcu_assertions.sv ----
`default_nettype none
module tcu_assertions
    import tcu_pkg::*;
(
    // Clock, reset, enable
    input wire logic             clock_in,
    input wire logic             rst_n_in,
    input wire logic             ce_in,
    // Register port
    input wire logic [4:0]       addr_in,
    input wire logic             wr_in,
    input wire logic             rd_in,
    input wire logic [7:0]       rd_data_out,
    // CPU side
    input wire logic             irq_ack_in,
    input wire logic             return_from_interrupt_op_in,
    input wire logic             irq_req_out,
    input wire logic [VEC_W-1:0] vector_out,
    input wire logic             stack_push_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    chk_push_after_ack: assert property (irq_ack_in && irq_req_out && ce_in |=> stack_push_out && !irq_req_out)
        else $error("accepted ack gave no push");
    chk_ack_refused: assert property (irq_ack_in && !irq_req_out |=> !stack_push_out)
        else $error("push without a request");
    chk_push_single: assert property (stack_push_out |=> !stack_push_out)
        else $error("push longer than one cycle");
    chk_req_off_handler: assert property (stack_push_out && !return_from_interrupt_op_in && !wr_in |=> !irq_req_out)
        else $error("request inside handler");
    // Past strobes excluded: a write or pending read may drop the cause
    chk_pend_hold: assert property (irq_req_out && ce_in && !irq_ack_in && !wr_in && !rd_in
        && !$past(wr_in) && !$past(rd_in) |=> irq_req_out) else $error("request lost without ack");
    chk_vec_range: assert property (irq_req_out |-> vector_out < 4'(NUM_SRC))
        else $error("vector out of range");
    chk_rd_idle: assert property (ce_in && !rd_in |=> rd_data_out == 8'h00)
        else $error("read data outside read slot");
    chk_rd_unmapped: assert property (ce_in && rd_in && addr_in > ADDR_PS2_MODE |=> rd_data_out == 8'h00)
        else $error("unmapped read not zero");
endmodule : tcu_assertions
`default_nettype wire

// ---- verif/tcu_top_tb.sv ----
`default_nettype none
module tcu_top_tb
    import tcu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clock_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, tb_ack = 1'b0;
    logic              bus_reset_in = 1'b0, wake_in = 1'b0, ps2_data_line_in = 1'b1, ce_in = 1'b1;
    logic [4:0]        addr_in = 5'h00;
    logic [7:0]        wr_data_in = 8'h00, rdv, seen = 8'h00, rd_data_out, cpu_cnt;
    logic [2:0]        ep_done_in = 3'h0;
    logic [GPIO_W-1:0] gpio_in = 16'h0000;
    logic [3:0]        delay = 4'h0, vector_out, cpu_vec;
    logic              irq_req_out, stack_push_out, cpu_ack, cpu_ret;
    int                fail_count = 0, n_checks = 0, cyc = 0;
    // 125 MHz clock and a free cycle count for period checks
    always #4 clock_in = ~clock_in;
    always @(posedge clock_in) cyc <= cyc + 1;
    tcu_top #(.GPIO_WIDTH(GPIO_W)) DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .bus_reset_in(bus_reset_in), .ep_done_in(ep_done_in), .wake_in(wake_in), .gpio_in(gpio_in),
        .ps2_data_line_in(ps2_data_line_in), .irq_ack_in(cpu_ack | tb_ack),
        .return_from_interrupt_op_in(cpu_ret), .irq_req_out(irq_req_out), .vector_out(vector_out),
        .stack_push_out(stack_push_out));
    tcu_cpu_model u_cpu (.clock_in(clock_in), .rst_n_in(rst_n_in), .irq_req_in(irq_req_out),
        .vector_in(vector_out), .ack_out(cpu_ack), .ret_out(cpu_ret), .delay_in(delay),
        .taken_vec_out(cpu_vec), .taken_cnt_out(cpu_cnt));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    // Bus cycles: one strobe cycle, read data sampled in the slot after it
    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr
    task rd(input logic [4:0] a);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        rdv = rd_data_out;
        @(posedge clock_in);
    endtask : rd
    task rdc(input logic [4:0] a, input logic [7:0] exp);
        rd(a);
        chk(rdv, exp);
    endtask : rdc
    // Wait for the CPU model to take one vector, bounded
    task take(input logic [3:0] v);
        int i;
        for (i = 0; i < 20000 && cpu_cnt === seen; i++) @(posedge clock_in);
        chk(i < 20000, 1);
        chk(cpu_vec, v);
        seen = cpu_cnt;
    endtask : take
    task none_taken;
        repeat (20) @(posedge clock_in);
        chk(cpu_cnt, seen);
    endtask : none_taken
    task t_mask;
        wr(ADDR_GLOBAL_EN, 8'h01);
        rdc(ADDR_CAP_CFG, 8'h00);
        rdc(5'h1f, 8'h00);
        @(posedge clock_in);
        wake_in <= 1'b1;
        tb_ack <= 1'b1;
        @(posedge clock_in);
        wake_in <= 1'b0;
        tb_ack <= 1'b0;
        none_taken;
        rdc(ADDR_PEND_HI, 8'h01);
        rdc(ADDR_PEND_HI, 8'h00);
        $display("test mask done");
    endtask : t_mask
    task t_prio;
        wr(ADDR_IRQ_EN_LO, 8'hf8);
        wr(ADDR_IRQ_EN_HI, 8'h01);
        delay <= 4'h9;
        ep_done_in <= 3'b101;
        wake_in <= 1'b1;
        @(posedge clock_in);
        ep_done_in <= 3'h0;
        wake_in <= 1'b0;
        take(4'(SRC_EP0));
        take(4'(SRC_EP0 + 2));
        take(4'(SRC_WAKE));
        delay <= 4'h0;
        $display("test priority done");
    endtask : t_prio
    task t_ps2;
        wr(ADDR_IRQ_EN_HI, 8'h00);
        wr(ADDR_IRQ_EN_LO, 8'h01);
        wr(ADDR_PS2_MODE, 8'h01);
        ps2_data_line_in <= 1'b0;
        take(4'(SRC_BUS_RESET));
        ps2_data_line_in <= 1'b1;
        bus_reset_in <= 1'b1;
        @(posedge clock_in);
        bus_reset_in <= 1'b0;
        take(4'(SRC_BUS_RESET));
        $display("test ps2 done");
    endtask : t_ps2
    task t_gpio;
        wr(ADDR_IRQ_EN_LO, 8'h00);
        wr(ADDR_IRQ_EN_HI, 8'h02);
        wr(ADDR_GMASK_P1, 8'h08);
        gpio_in[12] <= 1'b1;
        gpio_in[11] <= 1'b1;
        none_taken;
        wr(ADDR_GPOL_P1, 8'h08);
        gpio_in[11] <= 1'b0;
        none_taken;
        gpio_in[11] <= 1'b1;
        take(4'(SRC_GPIO));
        $display("test gpio done");
    endtask : t_gpio
    task t_cap;
        logic [7:0]  t0;
        logic [11:0] t12;
        wr(ADDR_IRQ_EN_HI, 8'h00);
        wr(ADDR_IRQ_EN_LO, 8'h40);
        wr(ADDR_CAP_CFG, 8'h28);
        rd(ADDR_TIMER_LO);
        t0 = rdv;
        gpio_in[0] <= 1'b1;
        gpio_in[2] <= 1'b1;
        rd(ADDR_TIMER_LO);
        take(4'(SRC_CAP_A));
        rd(ADDR_CAP_A_RISE);
        chk(rdv === t0 || rdv === t0 + 8'h01, 1);
        rdc(ADDR_CAP_STAT, 8'h01);
        wr(ADDR_CAP_CFG, 8'h42);
        gpio_in[1] <= 1'b1;
        rd(ADDR_TIMER_LO);
        t0 = rdv;
        rd(ADDR_TIMER_HI);
        gpio_in[1] <= 1'b0;
        t12 = {rdv[3:0], t0};
        repeat (2) @(posedge clock_in);
        rd(ADDR_CAP_B_FALL);
        chk(rdv === 8'(t12 >> 2) || rdv === 8'((t12 + 12'h001) >> 2), 1);
        rdc(ADDR_CAP_STAT, 8'h08);
        $display("test capture done");
    endtask : t_cap
    task t_timer;
        logic [7:0] v0;
        int         c0;
        rd(ADDR_TIMER_LO);
        v0 = rdv;
        repeat (997) @(posedge clock_in);
        rd(ADDR_TIMER_LO);
        chk(8'(rdv - v0), 8'h08);
        v0 = rdv;
        ce_in <= 1'b0;
        repeat (500) @(posedge clock_in);
        ce_in <= 1'b1;
        repeat (497) @(posedge clock_in);
        rd(ADDR_TIMER_LO);
        chk(8'(rdv - v0), 8'h04);
        wr(ADDR_IRQ_EN_LO, 8'h02);
        take(4'(SRC_TICK128));
        take(4'(SRC_TICK128));
        c0 = cyc;
        take(4'(SRC_TICK128));
        chk(cyc - c0, TICK128_US * TICK_CYCLES);
        $display("test timer done");
    endtask : t_timer
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    // Watchdog sized well above the longest tick wait
    initial begin
        repeat (60000) @(posedge clock_in);
        fail_count++;
        print_verdict;
    end
    initial begin
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        t_mask;
        t_prio;
        t_ps2;
        t_gpio;
        t_cap;
        t_timer;
        print_verdict;
    end
endmodule : tcu_top_tb
bind tcu_top tcu_assertions u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .irq_ack_in(irq_ack_in),
    .return_from_interrupt_op_in(return_from_interrupt_op_in), .irq_req_out(irq_req_out),
    .vector_out(vector_out), .stack_push_out(stack_push_out));
`default_nettype wire
